// ### verilog/sclkd_top.sv
// Purpose: system clock source select and divider with apb registers
// Assumes: oscillators arrive as sampled pin levels, slower than pclk/4
// Notes:   clocks are produced as one-cycle ticks on pclk, not as real clocks
//
// Notes on behaviour
// - reset starts on precision internal oscillator.
// - source 1: precision osc to pll or bypass.
// - source 2: precision osc quarter, bypass only.
// - source 0: main osc to pll or bypass.
// - source 3: low osc, bypass only.
// - ext source 7: hibernation osc, bypass only.
// - extended register fields override basic fields.
// - converter clock: precision osc, system clock, pll/25.
// - per-peripheral gate on system clock.
// - baud clock select at 0xfc8, default system clock.
// - divisor is basic divider plus one.
// - pll output halved before the divider.
// - extended divider six bits, up to 64.
// - fine enable appends low bit to divider.
// - fine enable clear ignores low bit.
// - fine divide only when pll used.
// - no divider_use, no pll: undivided source.
// - fine enable skips the pll halving.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sclkd_top (
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            clk_en,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [sclkd_pkg::NUM_OSC-1:0]   osc_pins,
  output logic                                 system_clock_out,
  output logic                                 conv_clk_tick,
  output logic      [sclkd_pkg::NUM_PERIPH-1:0] periph_clk_tick,
  output logic      [sclkd_pkg::NUM_SERIAL-1:0] baud_clk_tick,
  output logic                                 pll_enable,
  output logic                                 pll_ref_main
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic pll_ref_ok(input logic [2:0] src);
    pll_ref_ok = (src == sclkd_pkg::SRC_MAIN) || (src == sclkd_pkg::SRC_PREC);
  endfunction

  // ----------------------------------------
  // oscillator pin synchronisers
  // ----------------------------------------
  logic [sclkd_pkg::NUM_OSC-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, edge_reg;
  logic [sclkd_pkg::NUM_OSC-1:0] lvl_next, edge_next;

  genvar gi;
  generate
    for (gi = 0; gi < sclkd_pkg::NUM_OSC; gi++) begin : g_sync
      always_comb begin
        lvl_next[gi]  = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : lvl_reg[gi];
        edge_next[gi] = lvl_next[gi] & ~lvl_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      lvl_reg  <= '0;
      edge_reg <= '0;
    end else if (clk_en) begin
      s1_reg   <= osc_pins;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      lvl_reg  <= lvl_next;
      edge_reg <= edge_next;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  sclkd_pkg::sclkd_cfg_t     cfg_reg, cfg_next;
  sclkd_pkg::sclkd_cfg_ext_t ext_reg, ext_next;
  logic [sclkd_pkg::NUM_PERIPH-1:0] gate_reg, gate_next;
  logic [sclkd_pkg::NUM_SERIAL-1:0] baud_sel_reg, baud_sel_next;
  logic [1:0]  conv_sel_reg, conv_sel_next;
  logic [31:0] prdata_next;
  logic        pready_next, pslverr_next, wr_seen_reg, wr_seen_next;
  logic        hit, setup, access;
  logic [31:0] rd_word, status_word;

  // effective selection
  logic [2:0] sel_src;
  logic       sel_bypass, sel_pll_pd, fine_active, halve;
  logic [6:0] div_val;

  always_comb begin
    if (ext_reg.use_ext) begin
      sel_src    = ext_reg.ext_source_select;
      sel_bypass = ext_reg.ext_pll_skip;
      sel_pll_pd = ext_reg.pll_pd;
    end else begin
      sel_src    = {1'b0, cfg_reg.source_select};
      sel_bypass = cfg_reg.bypass;
      sel_pll_pd = cfg_reg.pll_pd;
    end
    fine_active = ext_reg.use_ext && ext_reg.fine_divide_enable && !ext_reg.ext_pll_skip;
    halve       = !fine_active;
    if (sel_bypass && !cfg_reg.divider_use) begin
      div_val = 7'h00;
    end else if (!ext_reg.use_ext) begin
      div_val = {3'h0, cfg_reg.sys_divider};
    end else if (fine_active) begin
      div_val = {ext_reg.ext_sys_divider, ext_reg.ext_divider_low_bit};
    end else begin
      div_val = {1'b0, ext_reg.ext_sys_divider};
    end
  end

  always_comb begin
    status_word = '0;
    status_word[2:0]  = sel_src;
    status_word[3]    = sel_bypass;
    status_word[4]    = pll_enable;
    status_word[14:8] = div_val;
  end

  assign setup  = psel && !penable;
  assign access = psel && penable && pready;

  always_comb begin
    hit     = 1'b1;
    rd_word = '0;
    case (paddr)
      sclkd_pkg::OFF_CFG:      rd_word = cfg_reg;
      sclkd_pkg::OFF_CFG_EXT:  rd_word = ext_reg;
      sclkd_pkg::OFF_CONV_SEL: rd_word = {30'h0, conv_sel_reg};
      sclkd_pkg::OFF_STATUS:   rd_word = status_word;
      sclkd_pkg::OFF_GATE:     rd_word = {24'h0, gate_reg};
      sclkd_pkg::OFF_BAUD_SEL: rd_word = {29'h0, baud_sel_reg};
      default:                 hit = 1'b0;
    endcase
  end

  always_comb begin
    cfg_next      = cfg_reg;
    ext_next      = ext_reg;
    gate_next     = gate_reg;
    baud_sel_next = baud_sel_reg;
    conv_sel_next = conv_sel_reg;
    wr_seen_next  = wr_seen_reg;
    prdata_next   = prdata;
    pslverr_next  = pslverr;
    pready_next   = 1'b0;
    if (setup) begin
      // no wait state: answer is prepared during setup, given in access
      pready_next  = 1'b1;
      pslverr_next = !hit;
      prdata_next  = pwrite ? 32'h0 : rd_word;
    end
    if (access && pwrite && hit) begin
      wr_seen_next = 1'b1;
      case (paddr)
        sclkd_pkg::OFF_CFG:      cfg_next = (pwdata & sclkd_pkg::CFG_WMASK) | (cfg_reg & ~sclkd_pkg::CFG_WMASK);
        sclkd_pkg::OFF_CFG_EXT:  ext_next = (pwdata & sclkd_pkg::CFG_EXT_WMASK) | (ext_reg & ~sclkd_pkg::CFG_EXT_WMASK);
        sclkd_pkg::OFF_CONV_SEL: conv_sel_next = pwdata[1:0];
        sclkd_pkg::OFF_GATE:     gate_next = pwdata[sclkd_pkg::NUM_PERIPH-1:0];
        sclkd_pkg::OFF_BAUD_SEL: baud_sel_next = pwdata[sclkd_pkg::NUM_SERIAL-1:0];
        default:                 wr_seen_next = wr_seen_reg;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg      <= sclkd_pkg::CFG_RESET;
      ext_reg      <= sclkd_pkg::CFG_EXT_RESET;
      gate_reg     <= sclkd_pkg::GATE_RESET;
      baud_sel_reg <= '0;
      conv_sel_reg <= '0;
      wr_seen_reg  <= 1'b0;
      prdata       <= '0;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
    end else if (clk_en) begin
      cfg_reg      <= cfg_next;
      ext_reg      <= ext_next;
      gate_reg     <= gate_next;
      baud_sel_reg <= baud_sel_next;
      conv_sel_reg <= conv_sel_next;
      wr_seen_reg  <= wr_seen_next;
      prdata       <= prdata_next;
      pready       <= pready_next;
      pslverr      <= pslverr_next;
    end
  end

  // ----------------------------------------
  // clock tree
  // ----------------------------------------
  logic [1:0] q4_cnt_reg, q4_cnt_next;
  logic       half_ph_reg, half_ph_next;
  logic [6:0] div_cnt_reg, div_cnt_next;
  logic [4:0] conv_cnt_reg, conv_cnt_next;
  logic       pio4_tick, pll_tick, src_tick, conv_pll_tick;
  logic       sys_next, conv_next, pll_en_next, ref_main_next;
  logic [sclkd_pkg::NUM_PERIPH-1:0] periph_next;
  logic [sclkd_pkg::NUM_SERIAL-1:0] baud_next;

  always_comb begin
    q4_cnt_next   = q4_cnt_reg;
    half_ph_next  = half_ph_reg;
    conv_cnt_next = conv_cnt_reg;
    div_cnt_next  = div_cnt_reg;
    if (edge_reg[sclkd_pkg::OSC_PREC]) begin
      q4_cnt_next = q4_cnt_reg + 2'h1;
    end
    pio4_tick = edge_reg[sclkd_pkg::OSC_PREC] && (q4_cnt_reg == sclkd_pkg::PIO4_LAST);
    // pll is unusable when its reference is not one it may take
    pll_en_next   = !sel_bypass && !sel_pll_pd && pll_ref_ok(sel_src);
    ref_main_next = (sel_src == sclkd_pkg::SRC_MAIN);
    if (edge_reg[sclkd_pkg::OSC_PLL]) begin
      half_ph_next  = !half_ph_reg;
      conv_cnt_next = (conv_cnt_reg == sclkd_pkg::CONV_DIV_LAST) ? 5'h00 : conv_cnt_reg + 5'h01;
    end
    pll_tick      = pll_enable && edge_reg[sclkd_pkg::OSC_PLL] && (!halve || half_ph_reg);
    conv_pll_tick = edge_reg[sclkd_pkg::OSC_PLL] && (conv_cnt_reg == sclkd_pkg::CONV_DIV_LAST);
    if (!sel_bypass) begin
      src_tick = pll_tick;
    end else begin
      case (sel_src)
        sclkd_pkg::SRC_MAIN:  src_tick = edge_reg[sclkd_pkg::OSC_MAIN];
        sclkd_pkg::SRC_PREC:  src_tick = edge_reg[sclkd_pkg::OSC_PREC];
        sclkd_pkg::SRC_PIO4:  src_tick = pio4_tick;
        sclkd_pkg::SRC_LFOSC: src_tick = edge_reg[sclkd_pkg::OSC_LF];
        sclkd_pkg::SRC_HIB:   src_tick = ext_reg.use_ext && edge_reg[sclkd_pkg::OSC_HIB];
        default:              src_tick = 1'b0;
      endcase
    end
    sys_next = 1'b0;
    if (src_tick) begin
      if (div_cnt_reg >= div_val) begin
        div_cnt_next = 7'h00;
        sys_next     = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + 7'h01;
      end
    end
    case (conv_sel_reg)
      2'h0:    conv_next = edge_reg[sclkd_pkg::OSC_PREC];
      2'h1:    conv_next = pll_enable ? conv_pll_tick : sys_next;
      default: conv_next = 1'b0;
    endcase
    periph_next = gate_reg & {sclkd_pkg::NUM_PERIPH{sys_next}};
    for (int i = 0; i < sclkd_pkg::NUM_SERIAL; i++) begin
      baud_next[i] = baud_sel_reg[i] ? edge_reg[sclkd_pkg::OSC_PREC] : sys_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q4_cnt_reg       <= '0;
      half_ph_reg      <= 1'b0;
      div_cnt_reg      <= '0;
      conv_cnt_reg     <= '0;
      system_clock_out <= 1'b0;
      conv_clk_tick    <= 1'b0;
      periph_clk_tick  <= '0;
      baud_clk_tick    <= '0;
      pll_enable       <= 1'b0;
      pll_ref_main     <= 1'b0;
    end else if (clk_en) begin
      q4_cnt_reg       <= q4_cnt_next;
      half_ph_reg      <= half_ph_next;
      div_cnt_reg      <= div_cnt_next;
      conv_cnt_reg     <= conv_cnt_next;
      system_clock_out <= sys_next;
      conv_clk_tick    <= conv_next;
      periph_clk_tick  <= periph_next;
      baud_clk_tick    <= baud_next;
      pll_enable       <= pll_en_next;
      pll_ref_main     <= ref_main_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    clk_en && psel && !penable;
  endsequence

  chk_por_source: assert property (!wr_seen_reg |-> sel_src == sclkd_pkg::SRC_PREC && sel_bypass)
    else $error("not on precision osc before first write");
  chk_pll_ref_only: assert property (clk_en && !pll_ref_ok(sel_src) |=> !pll_enable)
    else $error("pll enabled with forbidden reference");
  chk_ext_override: assert property (ext_reg.use_ext |-> sel_src == ext_reg.ext_source_select)
    else $error("extended source not applied");
  chk_div_wrap: assert property (clk_en && src_tick && div_cnt_reg >= div_val |=> system_clock_out && div_cnt_reg == 7'h00)
    else $error("divider did not wrap");
  chk_fine_half: assert property (fine_active && clk_en && edge_reg[sclkd_pkg::OSC_PLL] && pll_enable
                                  |=> system_clock_out || div_cnt_reg != $past(div_cnt_reg))
    else $error("pll halved under fine divide");
  chk_fine_ignored: assert property (ext_reg.use_ext && !fine_active && (!sel_bypass || cfg_reg.divider_use)
                                     |-> div_val == {1'b0, ext_reg.ext_sys_divider})
    else $error("low bit used without fine divide");
  chk_undivided: assert property (sel_bypass && !cfg_reg.divider_use |-> div_val == 7'h00)
    else $error("bypass without divider_use is divided");
  chk_baud_sys: assert property (clk_en && !baud_sel_reg[0] |=> baud_clk_tick[0] == $past(sys_next))
    else $error("baud clock not following system_clock_out");
  chk_gate_off: assert property (clk_en && !gate_reg[0] |=> !periph_clk_tick[0])
    else $error("gated peripheral still ticking");
  chk_apb_ready: assert property (apb_setup_s |=> pready ##1 !pready || !clk_en)
    else $error("apb wait state wrong");

endmodule

`default_nettype wire

// ### verilog/sclkd_pkg.sv
// Purpose: shared constants and register layouts of the system clock source/divider
// Assumes: 32-bit apb data, 12-bit register offsets
// Notes:   field layouts travel as packed structs
`default_nettype none
package sclkd_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_CFG      = 12'h060;
  localparam logic [11:0] OFF_CFG_EXT  = 12'h070;
  localparam logic [11:0] OFF_CONV_SEL = 12'h0f0;
  localparam logic [11:0] OFF_STATUS   = 12'h0f4;
  localparam logic [11:0] OFF_GATE     = 12'h108;
  localparam logic [11:0] OFF_BAUD_SEL = 12'hfc8;

  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [31:0] CFG_RESET     = 32'h0780_2810;
  localparam logic [31:0] CFG_EXT_RESET = 32'h0780_2810;
  localparam logic [31:0] CFG_WMASK     = 32'h07c0_2830;
  localparam logic [31:0] CFG_EXT_WMASK = 32'hdfc0_2870;
  localparam logic [7:0]  GATE_RESET    = 8'h00;
  localparam int          NUM_PERIPH    = 8;
  localparam int          NUM_SERIAL    = 3;

  // ----------------------------------------
  // source select codes
  // ----------------------------------------
  localparam logic [2:0] SRC_MAIN  = 3'h0;
  localparam logic [2:0] SRC_PREC  = 3'h1;
  localparam logic [2:0] SRC_PIO4  = 3'h2;
  localparam logic [2:0] SRC_LFOSC = 3'h3;
  localparam logic [2:0] SRC_HIB   = 3'h7;

  // oscillator pin indices
  localparam int OSC_MAIN  = 0;
  localparam int OSC_PREC  = 1;
  localparam int OSC_LF    = 2;
  localparam int OSC_HIB   = 3;
  localparam int OSC_PLL   = 4;
  localparam int NUM_OSC   = 5;

  // ----------------------------------------
  // frequencies and derived divisions
  // ----------------------------------------
  localparam int PLL_OSC_MHZ   = 400;
  localparam int CONV_MHZ      = 16;
  localparam int CONV_DIV      = PLL_OSC_MHZ / CONV_MHZ;
  localparam logic [4:0] CONV_DIV_LAST = 5'(CONV_DIV - 1);
  localparam logic [1:0] PIO4_LAST     = 2'h3;

  // ----------------------------------------
  // register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] rsv_hi;
    logic [3:0] sys_divider;
    logic       divider_use;
    logic [7:0] rsv_mid;
    logic       pll_pd;
    logic       rsv_a;
    logic       bypass;
    logic [4:0] rsv_b;
    logic [1:0] source_select;
    logic [3:0] rsv_lo;
  } sclkd_cfg_t;

  typedef struct packed {
    logic       use_ext;
    logic       fine_divide_enable;
    logic       rsv_hi;
    logic [5:0] ext_sys_divider;
    logic       ext_divider_low_bit;
    logic [7:0] rsv_mid;
    logic       pll_pd;
    logic       rsv_a;
    logic       ext_pll_skip;
    logic [3:0] rsv_b;
    logic [2:0] ext_source_select;
    logic [3:0] rsv_lo;
  } sclkd_cfg_ext_t;

endpackage
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench for the system clock source and divider
// Assumes: apb answers within a bounded wait; oscillator pins toggle every 4 pclk
// Notes:   counted ticks are compared with the expected counts passed to each run
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                          pclk     = 1'b0;
  logic                          presetn  = 1'b0;
  logic                          clk_en   = 1'b1;
  logic                          psel     = 1'b0;
  logic                          penable  = 1'b0;
  logic                          pwrite   = 1'b0;
  logic [11:0]                   paddr    = 12'h000;
  logic [31:0]                   pwdata   = 32'h0000_0000;
  logic [sclkd_pkg::NUM_OSC-1:0] osc_pins = 5'h00;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          system_clock_out;
  logic                          conv_clk_tick;
  logic [7:0]                    periph_clk_tick;
  logic [2:0]                    baud_clk_tick;
  logic                          pll_enable;
  logic                          pll_ref_main;
  int                            error_cnt   = 0;
  int                            check_count = 0;
  int                            seed        = 32'he4f0be08;
  logic                          cnt_on      = 1'b0;
  int                            n_sys;
  int                            n_conv;
  int                            n_per[8];
  int                            n_baud[3];
  logic [31:0]                   rd;
  logic                          er;
  logic [7:0]                    gate_m;
  logic [2:0]                    baud_m;
  int                            d;
  int                            srcs[4] = '{0, 1, 3, 2};
  int                            pins[4] = '{0, 1, 2, 1};
  int                            ns[4]   = '{6, 6, 6, 24};

  sclkd_top sclkd_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_pins(osc_pins), .system_clock_out(system_clock_out), .conv_clk_tick(conv_clk_tick),
    .periph_clk_tick(periph_clk_tick), .baud_clk_tick(baud_clk_tick), .pll_enable(pll_enable),
    .pll_ref_main(pll_ref_main));

  always #5 pclk = ~pclk;

  // ----------------------------------------
  // tick counters
  // ----------------------------------------
  always @(posedge pclk) begin
    if (cnt_on) begin
      if (system_clock_out === 1'b1) n_sys++;
      if (conv_clk_tick === 1'b1) n_conv++;
      for (int i = 0; i < 8; i++) if (periph_clk_tick[i] === 1'b1) n_per[i]++;
      for (int i = 0; i < 3; i++) if (baud_clk_tick[i] === 1'b1) n_baud[i]++;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // entered just after a rising edge; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("apb_wait", 32'h0000_0001, n);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  function automatic logic [31:0] bcfg(input int src, input int byp, input int pd, input int du, input int dv);
    return (32'(dv) << 23) | (32'(du) << 22) | (32'(pd) << 13) | (32'(byp) << 11) | (32'(src) << 4);
  endfunction

  function automatic logic [31:0] ecfg(input int fine, input int dv, input int lsb, input int pd, input int skip,
                                       input int src);
    return 32'h8000_0000 | (32'(fine) << 30) | (32'(dv) << 23) | (32'(lsb) << 22) | (32'(pd) << 13)
           | (32'(skip) << 11) | (32'(src) << 4);
  endfunction

  // basic first, another access between, then extended; both read back through the write masks
  task automatic setcfg(input logic [31:0] b, input logic [31:0] e);
    apb(1'b1, sclkd_pkg::OFF_CFG, b);
    rchk("gate_reg", sclkd_pkg::OFF_GATE, {24'h0, gate_m});
    apb(1'b1, sclkd_pkg::OFF_CFG_EXT, e);
    rchk("cfg_reg", sclkd_pkg::OFF_CFG, b & sclkd_pkg::CFG_WMASK);
    rchk("cfg_ext_reg", sclkd_pkg::OFF_CFG_EXT, e & sclkd_pkg::CFG_EXT_WMASK);
  endtask

  task automatic edge1(input int pin);
    osc_pins[pin] <= 1'b1;
    repeat (4) @(posedge pclk);
    osc_pins[pin] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // warm-up flushes any divider phase left from the previous setting
  task automatic run(input int pin, input int n, input int e_sys, input int e_conv, input logic e_pll,
                     input logic e_main, input logic [4:0] e_st);
    repeat (130) edge1(pin);
    n_sys = 0;
    n_conv = 0;
    n_per = '{default: 0};
    n_baud = '{default: 0};
    cnt_on <= 1'b1;
    repeat (n) edge1(pin);
    cnt_on <= 1'b0;
    @(posedge pclk);
    chk("sys_ticks", e_sys, n_sys);
    chk("conv_ticks", e_conv, n_conv);
    for (int i = 0; i < 8; i++) chk("periph_ticks", gate_m[i] ? e_sys : 0, n_per[i]);
    for (int i = 0; i < 3; i++) chk("baud_ticks", baud_m[i] ? (pin == 1 ? n : 0) : e_sys, n_baud[i]);
    chk("pll_enable", e_pll, pll_enable);
    chk("pll_ref_main", e_main, pll_ref_main);
    apb(1'b0, sclkd_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status", e_st, rd & 32'h1f);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("cfg_reset", sclkd_pkg::OFF_CFG, sclkd_pkg::CFG_RESET);
    rchk("cfg_ext_reset", sclkd_pkg::OFF_CFG_EXT, sclkd_pkg::CFG_EXT_RESET);
    rchk("gate_reset", sclkd_pkg::OFF_GATE, 32'h0000_0000);
    rchk("baud_reset", sclkd_pkg::OFF_BAUD_SEL, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    chk("unmapped_err", 1'b1, er);
    rchk("unmapped_data", 12'h004, 32'h0000_0000);
    gate_m = 8'($random(seed));
    baud_m = 3'($random(seed));
    apb(1'b1, sclkd_pkg::OFF_GATE, {24'h0, gate_m});
    apb(1'b1, sclkd_pkg::OFF_BAUD_SEL, {29'h0, baud_m});
    apb(1'b1, sclkd_pkg::OFF_CONV_SEL, 32'h0000_0000);
    rchk("baud_reg", sclkd_pkg::OFF_BAUD_SEL, {29'h0, baud_m});
    run(1, 8, 8, 8, 1'b0, 1'b0, 5'h09);
    // clock enable low: pin edges must leave the system and converter ticks frozen
    clk_en <= 1'b0;
    n_sys = 0;
    n_conv = 0;
    cnt_on <= 1'b1;
    repeat (8) edge1(1);
    cnt_on <= 1'b0;
    clk_en <= 1'b1;
    @(posedge pclk);
    chk("frozen_sys", 32'h0000_0000, n_sys);
    chk("frozen_conv", 32'h0000_0000, n_conv);
    for (int k = 0; k < 4; k++) begin
      setcfg(bcfg(srcs[k], 1, 1, 0, 15), sclkd_pkg::CFG_EXT_RESET);
      run(pins[k], ns[k], 6, pins[k] == 1 ? ns[k] : 0, 1'b0, srcs[k] == 0, 5'(8 + srcs[k]));
    end
    setcfg(bcfg(1, 1, 1, 0, 15), sclkd_pkg::CFG_EXT_RESET);
    run(0, 6, 0, 0, 1'b0, 1'b0, 5'h09);
    setcfg(bcfg(1, 1, 1, 0, 15), ecfg(0, 0, 0, 1, 1, 7));
    run(3, 6, 6, 0, 1'b0, 1'b0, 5'h0f);
    for (int k = 0; k < 3; k++) begin
      d = {$random(seed)} % 16;
      setcfg(bcfg(1, 1, 1, 1, d), sclkd_pkg::CFG_EXT_RESET);
      run(1, 3 * (d + 1), 3, 3 * (d + 1), 1'b0, 1'b0, 5'h09);
    end
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 63 : {$random(seed)} % 64;
      setcfg(bcfg(0, 1, 1, 1, 15), ecfg(0, d, 0, 1, 1, 1));
      run(1, 2 * (d + 1), 2, 2 * (d + 1), 1'b0, 1'b0, 5'h09);
    end
    setcfg(bcfg(1, 1, 1, 1, 15), ecfg(1, 3, 1, 1, 1, 1));
    run(1, 12, 3, 12, 1'b0, 1'b0, 5'h09);
    apb(1'b1, sclkd_pkg::OFF_CONV_SEL, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      setcfg(bcfg(1 - k, 0, 0, 1, 4), sclkd_pkg::CFG_EXT_RESET);
      run(4, 50, 5, 2, 1'b1, k == 1, 5'(17 - k));
    end
    setcfg(bcfg(1, 0, 0, 1, 4), ecfg(1, 2, 0, 0, 0, 1));
    run(4, 50, 10, 2, 1'b1, 1'b0, 5'h11);
    setcfg(bcfg(1, 0, 0, 1, 4), ecfg(0, 4, 1, 0, 0, 1));
    run(4, 50, 5, 2, 1'b1, 1'b0, 5'h11);
    for (int k = 2; k < 4; k++) begin
      setcfg(bcfg(k, 0, 0, 1, 4), sclkd_pkg::CFG_EXT_RESET);
      run(4, 50, 0, 0, 1'b0, 1'b0, 5'(k));
    end
    // second reset mid-run: everything falls back to the undivided precision osc
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("cfg_rst2", sclkd_pkg::OFF_CFG, sclkd_pkg::CFG_RESET);
    rchk("status_rst2", sclkd_pkg::OFF_STATUS, 32'h0000_0009);
    end_sim();
  end

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #600_000;
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    end_sim();
  end
endmodule

`default_nettype wire
